// ==== include/sfr_paging_consts.svh ====
`ifndef SFR_PAGING_CONSTS_SVH
`define SFR_PAGING_CONSTS_SVH

// ----------------------------------------------------------------
// register space bounds
// ----------------------------------------------------------------
`define SFR_BASE          8'h80
`define SFR_PAGE_DEFAULT  8'h00
`define SFR_PAGE_ALT      8'h0f

// ----------------------------------------------------------------
// local register offsets and reset values
// ----------------------------------------------------------------
`define SFR_PAGE_SEL_ADDR 8'ha7
`define XRAM_PAGE_ADDR    8'haa
`define SFR_PAGE_SEL_RST  8'h00
`define XRAM_PAGE_RST     4'h0

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define XRAM_FIELD_MSB    3
`define XRAM_HI_ZERO      4'h0
`define BIT_ADDR_NIBBLE   3'h0

// one bit per address 0x80..0xff, set where page 0x0 and 0xf share
`define SHARED_MASK 128'h00c1_00c1_0001_0000_0000_0381_0001_008f

`endif

// ==== include/sfr_paging_pkg.sv ====
package sfr_paging_pkg;

    // access request from the core, one cycle wide
    typedef struct packed {
        logic       valid;    // access this cycle
        logic       write;    // 1 write, 0 read
        logic       direct;   // direct addressing mode
        logic       rmw;      // read-modify-write access
        logic       bitop;    // single-bit access
        logic [2:0] bit_idx;  // bit position
        logic       bit_val;  // bit value for a bit write
        logic [7:0] addr;     // data address
        logic [7:0] wdata;    // byte to write
    } core_req_s;

    // 8-bit pointer external data move
    typedef struct packed {
        logic       valid;    // move issued this cycle
        logic       ptr_sel;  // 0 uses r0, 1 uses r1
        logic [7:0] r0;       // general register r0
        logic [7:0] r1;       // general register r1
    } movx8_s;

    // decode result toward peripherals and ram
    typedef struct packed {
        logic       sfr_sel;     // register space hit
        logic       iram_hi_sel; // upper internal ram hit
        logic       bit_ok;      // bit access legal here
        logic       shared;      // same register on 0x0 and 0xf
        logic       local_hit;   // answered by this block
        logic [7:0] page;        // page seen by peripherals
        logic [7:0] addr;        // address passed on
    } decode_s;

    // whole state of the block
    typedef struct packed {
        logic [7:0]  sfr_page;   // page select register
        logic [3:0]  xram_page;  // xram page field
        logic [7:0]  rdata;      // read data to the core
        logic        rvalid;     // read data valid
        logic [15:0] xram_addr;  // formed external address
        logic        xvalid;     // external address valid
    } state_s;

endpackage

// ==== logic/sfr_paging_and_xram_page.sv ====
`timescale 1ns/1ps
`include "sfr_paging_consts.svh"

// Functional notes
// (RQ1) direct 0x80-0xff goes to register space
// (RQ2) nibble 0x0/0x8 registers also bit access
// (RQ3) software avoids unoccupied register locations
// (RQ4) page register selects among overlapping registers
// (RQ5) default page 0x0 from reset
// (RQ6) shared registers decode alike on 0x0, 0xf
// (RQ7) software guards page 0xf use with interrupts off
// (RQ8) page select: 8-bit rw at 0xa7, reset zero
// (RQ9) page applies to read, write, modify alike
// (RQ10) xram page register at 0xaa page 0
// (RQ11) xram page upper nibble reads zero
// (RQ12) 8-bit move high byte from xram page
// (RQ13) 8-bit move low byte from r0/r1
// (RQ14) indirect above 0x7f reaches upper ram
// (RQ15) page write effective for very next access
module sfr_paging_and_xram_page (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    // core access
    input  wire sfr_paging_pkg::core_req_s   req,
    input  wire logic [7:0]                  periph_rdata,
    // 8-bit pointer move
    input  wire sfr_paging_pkg::movx8_s      movx,
    // decode toward peripherals
    output      sfr_paging_pkg::decode_s     dec,
    // answers to the core
    output      logic [7:0]                  rdata,
    output      logic                        rvalid,
    output      logic [15:0]                 xram_addr,
    output      logic                        xram_valid,
    output      logic [7:0]                  sfr_page,
    output      logic [7:0]                  xram_page_sel
);
    import sfr_paging_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_s      st_r;       // registered state
    state_s      st_nxt;     // next state
    logic [6:0]  sh_idx;     // index into shared mask
    logic        hit_page;   // access hits page select
    logic        hit_xram;   // access hits xram page
    logic [7:0]  cur_byte;   // old value for bit writes
    logic [7:0]  new_byte;   // value after the write
    logic [7:0]  xram_rd;    // xram page as read
    localparam logic [127:0] shared_map = `SHARED_MASK; // a literal cannot be bit-selected

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // decode is combinational on the registered page, so a page
    // write lands in time for the next access without wait states
    always_comb begin
        sh_idx          = req.addr[6:0];
        dec             = '0;
        dec.addr        = req.addr;
        // direct high half is register space, never ram
        dec.sfr_sel     = req.valid && req.direct && req.addr[7]; // [RQ1]
        // indirect high half is ram, never registers
        dec.iram_hi_sel = req.valid && !req.direct && req.addr[7]; // [RQ14]
        // only nibble 0x0 / 0x8 allow single-bit access
        dec.bit_ok      = dec.sfr_sel && (req.addr[2:0] == `BIT_ADDR_NIBBLE); // [RQ2]
        dec.shared      = req.addr[7] && shared_map[sh_idx];
        // shared registers are folded onto page 0x0 when 0xf is set
        if (dec.shared && st_r.sfr_page == `SFR_PAGE_ALT) begin
            dec.page = `SFR_PAGE_DEFAULT; // [RQ6]
        end else begin
            dec.page = st_r.sfr_page; // [RQ4] [RQ9]
        end
        // page select answers on every page
        hit_page = dec.sfr_sel && req.addr == `SFR_PAGE_SEL_ADDR; // [RQ8]
        // xram page lives on page 0x0 only
        hit_xram = dec.sfr_sel && req.addr == `XRAM_PAGE_ADDR
                   && st_r.sfr_page == `SFR_PAGE_DEFAULT; // [RQ10]
        dec.local_hit = hit_page || hit_xram;
    end

    // ------------------------------------------------------------
    // byte view of the local registers
    // ------------------------------------------------------------
    // unused upper nibble is never stored, so it reads zero
    always_comb begin
        xram_rd  = {`XRAM_HI_ZERO, st_r.xram_page}; // [RQ11]
        cur_byte = hit_page ? st_r.sfr_page : xram_rd;
        new_byte = req.wdata;
        // bit form kept for completeness; neither local register
        // sits on a bit-addressable nibble, so bit writes here drop
        if (req.bitop) begin
            new_byte = cur_byte;
            new_byte[req.bit_idx] = req.bit_val;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.xvalid = 1'b0;
        // register writes, byte form or legal bit form only
        if (req.valid && req.write && (!req.bitop || dec.bit_ok)) begin
            if (hit_page) begin
                st_nxt.sfr_page = new_byte; // [RQ8] [RQ15]
            end else if (hit_xram) begin
                // upper nibble of the write is dropped
                st_nxt.xram_page = new_byte[`XRAM_FIELD_MSB:0]; // [RQ11]
            end else begin
                st_nxt.sfr_page = st_r.sfr_page; // peripheral write
            end
        end
        // reads, including the read half of read-modify-write
        if (req.valid && (!req.write || req.rmw) && dec.sfr_sel) begin
            st_nxt.rvalid = 1'b1;
            if (hit_page) begin
                st_nxt.rdata = st_r.sfr_page; // [RQ9]
            end else if (hit_xram) begin
                st_nxt.rdata = xram_rd; // [RQ11]
            end else begin
                // unoccupied locations just return what the bus holds
                st_nxt.rdata = periph_rdata;
            end
        end
        // 8-bit pointer move address
        if (movx.valid) begin
            st_nxt.xvalid = 1'b1;
            st_nxt.xram_addr[15:8] = xram_rd; // [RQ12]
            if (movx.ptr_sel) begin
                st_nxt.xram_addr[7:0] = movx.r1; // [RQ13]
            end else begin
                st_nxt.xram_addr[7:0] = movx.r0; // [RQ13]
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r           <= '0;
            st_r.sfr_page  <= `SFR_PAGE_SEL_RST; // [RQ5]
            st_r.xram_page <= `XRAM_PAGE_RST; // [RQ10]
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata         = st_r.rdata;
    assign rvalid        = st_r.rvalid;
    assign xram_addr     = st_r.xram_addr;
    assign xram_valid    = st_r.xvalid;
    assign sfr_page      = st_r.sfr_page;
    assign xram_page_sel = xram_rd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // a byte write to the page select
    sequence s_page_wr;
        req.valid && req.write && !req.bitop && req.direct
            && req.addr == `SFR_PAGE_SEL_ADDR;
    endsequence

    // a direct read of the page select
    sequence s_page_rd;
        req.valid && !req.write && req.direct
            && req.addr == `SFR_PAGE_SEL_ADDR;
    endsequence

    property p_direct_sfr;
        req.valid && req.direct && req.addr >= `SFR_BASE
            |-> dec.sfr_sel && !dec.iram_hi_sel;
    endproperty
    a_direct_sfr: assert property (p_direct_sfr) // [RQ1]
        else $error("direct high access not sent to register space");

    property p_bit_ok;
        dec.sfr_sel |-> dec.bit_ok == (dec.addr[2:0] == 3'h0);
    endproperty
    a_bit_ok: assert property (p_bit_ok) // [RQ2]
        else $error("bit access flag wrong for address");

    property p_page_follows;
        !dec.shared |-> dec.page == sfr_page;
    endproperty
    a_page_follows: assert property (p_page_follows) // [RQ4]
        else $error("page out differs from page register");

    property p_reset_zero;
        @(posedge mclk) $fell(sys_rst) |-> sfr_page == 8'h00 && xram_page_sel == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // [RQ5]
        else $error("registers not zero after reset");

    property p_shared_fold;
        dec.shared && sfr_page == `SFR_PAGE_ALT |-> dec.page == `SFR_PAGE_DEFAULT;
    endproperty
    a_shared_fold: assert property (p_shared_fold) // [RQ6]
        else $error("shared register not folded onto page 0x0");

    property p_page_write;
        s_page_wr |=> sfr_page == $past(req.wdata)
            && (dec.page == $past(req.wdata) || dec.shared);
    endproperty
    a_page_write: assert property (p_page_write) // [RQ8] [RQ15]
        else $error("page write not seen next cycle");

    property p_page_read;
        s_page_rd |=> rvalid && rdata == $past(sfr_page);
    endproperty
    a_page_read: assert property (p_page_read) // [RQ9]
        else $error("page read returned wrong value");

    property p_xram_hi;
        xram_page_sel[7:4] == 4'h0;
    endproperty
    a_xram_hi: assert property (p_xram_hi) // [RQ11]
        else $error("xram page upper nibble not zero");

    property p_movx_addr;
        movx.valid |=> xram_valid && xram_addr[15:8] == $past(xram_page_sel)
            && xram_addr[7:0] == ($past(movx.ptr_sel) ? $past(movx.r1) : $past(movx.r0));
    endproperty
    a_movx_addr: assert property (p_movx_addr) // [RQ12] [RQ13]
        else $error("8-bit move address formed wrongly");

    property p_indirect_ram;
        req.valid && !req.direct && req.addr[7] |-> dec.iram_hi_sel && !dec.sfr_sel;
    endproperty
    a_indirect_ram: assert property (p_indirect_ram) // [RQ14]
        else $error("indirect high access reached register space");

    // a byte write to the xram page while page 0x0 is selected
    sequence s_xram_wr;
        req.valid && req.write && !req.bitop && req.direct
            && req.addr == `XRAM_PAGE_ADDR && sfr_page == `SFR_PAGE_DEFAULT;
    endsequence

    // a direct read of the xram page while page 0x0 is selected
    sequence s_xram_rd;
        req.valid && !req.write && req.direct
            && req.addr == `XRAM_PAGE_ADDR && sfr_page == `SFR_PAGE_DEFAULT;
    endsequence

    // the read half of a page modify returns the page before the write
    property p_page_rmw;
        s_page_wr ##0 req.rmw |=> rvalid && rdata == $past(sfr_page);
    endproperty
    a_page_rmw: assert property (p_page_rmw) // [RQ9]
        else $error("page modify returned wrong old value");

    // only the low nibble of an xram page write is kept
    property p_xram_write;
        s_xram_wr |=> xram_page_sel == {4'h0, $past(req.wdata[3:0])};
    endproperty
    a_xram_write: assert property (p_xram_write) // [RQ10] [RQ11]
        else $error("xram page write not stored as low nibble");

    // xram page reads give the stored nibble over zeros
    property p_xram_read;
        s_xram_rd |=> rvalid && rdata == {4'h0, $past(xram_page_sel[3:0])};
    endproperty
    a_xram_read: assert property (p_xram_read) // [RQ10] [RQ11]
        else $error("xram page read returned wrong value");

    // local registers are not bit addressable, bit writes leave them
    property p_bit_refused;
        req.valid && req.write && req.bitop && dec.local_hit
            |=> $stable(sfr_page) && $stable(xram_page_sel);
    endproperty
    a_bit_refused: assert property (p_bit_refused) // [RQ2]
        else $error("bit write changed a local register");

    // default page means every access lands on page 0x0
    property p_default_page;
        sfr_page == `SFR_PAGE_DEFAULT |-> dec.page == `SFR_PAGE_DEFAULT;
    endproperty
    a_default_page: assert property (p_default_page) // [RQ5]
        else $error("default page not presented as page 0x0");

    // page select answers here on every page and is shared
    property p_page_any;
        req.valid && req.direct && req.addr == `SFR_PAGE_SEL_ADDR
            |-> dec.local_hit && dec.shared;
    endproperty
    a_page_any: assert property (p_page_any) // [RQ6] [RQ8]
        else $error("page select not reachable on this page");

    // a read answer only follows a direct register-space read
    property p_rvalid_src;
        rvalid |-> $past(req.valid && req.direct && req.addr[7] && (!req.write || req.rmw));
    endproperty
    a_rvalid_src: assert property (p_rvalid_src) // [RQ1]
        else $error("read answer without a register read");

    // indirect accesses never produce a register read answer
    property p_indirect_no_read;
        req.valid && !req.direct |=> !rvalid;
    endproperty
    a_indirect_no_read: assert property (p_indirect_no_read) // [RQ14]
        else $error("indirect access answered from register space");

    // a move address pulse only follows a move request
    property p_xvalid_src;
        xram_valid |-> $past(movx.valid);
    endproperty
    a_xvalid_src: assert property (p_xvalid_src) // [RQ12]
        else $error("move address pulse without a move");

    // the formed address holds between moves
    property p_movx_hold;
        !movx.valid |=> $stable(xram_addr);
    endproperty
    a_movx_hold: assert property (p_movx_hold) // [RQ12]
        else $error("move address changed without a move");

endmodule // sfr_paging_and_xram_page

// ==== verif/core_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// core side: issues accesses and 8-bit moves
// ----------------------------------------------------------------
module core_model (
    // clock
    input  wire logic                  mclk,
    // toward the block
    output sfr_paging_pkg::core_req_s  req,
    output sfr_paging_pkg::movx8_s     movx,
    output logic [7:0]                 periph_rdata
);
    import sfr_paging_pkg::*;

    // quiet bus at time zero
    initial begin
        req = '0;
        movx = '0;
        periph_rdata = 8'h5a;
    end

    // k = {write, direct, rmw, bitop}; held until the next put or idle
    task automatic put(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, k[3], k[2], k[1], k[0], 3'h2, 1'b0, a, d};
    endtask

    // one 8-bit move, low byte from r0 or r1
    task automatic mv(input logic s, input logic [7:0] a, input logic [7:0] b);
        movx = '{1'b1, s, a, b};
    endtask

    // land just after the edge that takes the request
    task automatic step;
        @(posedge mclk);
        #2;
    endtask

    // release: peripheral byte flips so a stale value never matches;
    // one quiet edge passes so the next put never lands in this step
    task automatic idle;
        req.valid = 1'b0;
        movx.valid = 1'b0;
        periph_rdata = ~periph_rdata;
        step;
    endtask
endmodule // core_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module tb_top;
    import sfr_paging_pkg::*;

    logic       mclk;                    // 50 ns clock
    logic       sys_rst;                 // sync reset
    core_req_s  req;                     // access from core
    movx8_s     movx;                    // move from core
    logic [7:0] periph_rdata;            // peripheral byte
    decode_s    dec;                     // decode out
    logic [7:0] rdata;                   // read byte
    logic       rvalid;                  // read pulse
    logic [15:0] xram_addr;              // formed address
    logic       xram_valid;              // move pulse
    logic [7:0] sfr_page;                // page register
    logic [7:0] xram_page_sel;           // xram page as read
    logic       global_interrupt_enable; // core interrupt state
    logic [7:0] pr;                      // captured peripheral byte
    int         fail_count;
    int         checks;

    core_model core (.mclk(mclk), .req(req), .movx(movx), .periph_rdata(periph_rdata));

    sfr_paging_and_xram_page uut (.mclk(mclk), .sys_rst(sys_rst), .req(req),
        .periph_rdata(periph_rdata), .movx(movx), .dec(dec), .rdata(rdata),
        .rvalid(rvalid), .xram_addr(xram_addr), .xram_valid(xram_valid),
        .sfr_page(sfr_page), .xram_page_sel(xram_page_sel));

    // free running clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("fail_count=%0d checks=%0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // reset values and default page
    task automatic t_reset;
        chk({sfr_page, xram_page_sel}, 16'h0000);
        core.put(4'h4, 8'hb1, 8'h00);
        #1;
        chk(dec.page, 8'h00);
        core.step;
        chk(rvalid, 1'b1);
        core.idle;
    endtask

    // address space steering and bit access
    task automatic t_decode;
        logic [7:0] a;
        core.put(4'h4, 8'h7f, 8'h00);
        #1;
        chk({dec.sfr_sel, dec.iram_hi_sel}, 2'b00);
        core.step;
        chk(rvalid, 1'b0);
        core.put(4'h4, 8'hff, 8'h00);
        #1;
        chk({dec.sfr_sel, dec.iram_hi_sel}, 2'b10);
        core.step;
        chk(rvalid, 1'b1);
        core.put(4'h0, 8'h80, 8'h00);
        #1;
        chk({dec.sfr_sel, dec.iram_hi_sel}, 2'b01);
        core.step;
        chk(rvalid, 1'b0);
        for (int i = 0; i < 15; i++) begin
            a = 8'h80 + 8'(i * 9);
            core.put(4'h5, a, 8'h00);
            #1;
            chk(dec.bit_ok, a[2:0] == 3'h0);
            core.step;
        end
        core.idle;
    endtask

    // page 0xf visit, back to back accesses
    task automatic t_page;
        logic ea_save;
        ea_save = global_interrupt_enable;
        global_interrupt_enable = 1'b0;
        core.put(4'hc, 8'ha7, 8'h0f);
        core.step;
        core.put(4'h4, 8'hba, 8'h00);
        #1;
        chk({dec.shared, dec.page}, 9'h00f);
        core.step;
        core.put(4'h4, 8'ha7, 8'h00);
        #1;
        chk({dec.shared, dec.local_hit, dec.page}, 10'h300);
        core.step;
        chk(rdata, 8'h0f);
        core.put(4'he, 8'hbd, 8'h11);
        pr = periph_rdata;
        #1;
        chk(dec.page, 8'h0f);
        core.step;
        chk(rdata, pr);
        core.put(4'he, 8'ha7, 8'hff);
        core.step;
        chk(sfr_page, 8'hff);
        chk(rdata, 8'h0f);
        core.put(4'hc, 8'ha7, 8'h00);
        core.step;
        chk(sfr_page, 8'h00);
        core.idle;
        global_interrupt_enable = ea_save;
    endtask

    // xram page register and 8-bit moves
    task automatic t_xram;
        core.put(4'hc, 8'haa, 8'hf5);
        core.step;
        core.put(4'h4, 8'haa, 8'h00);
        #1;
        chk(dec.local_hit, 1'b1);
        core.step;
        chk({rdata, xram_page_sel}, 16'h0505);
        core.put(4'hd, 8'haa, 8'h00);
        #1;
        chk(dec.bit_ok, 1'b0);
        core.step;
        core.idle;
        chk(xram_page_sel, 8'h05);
        core.mv(1'b0, 8'h34, 8'hc2);
        core.step;
        chk({15'h0, xram_valid}, 16'h0001);
        chk(xram_addr, 16'h0534);
        core.mv(1'b1, 8'h34, 8'hc2);
        core.step;
        chk(xram_addr, 16'h05c2);
        core.idle;
    endtask

    // guard against a hung run
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        report_and_stop;
    end

    // main sequence
    initial begin
        fail_count = 0;
        checks = 0;
        global_interrupt_enable = 1'b1;
        pr = 8'h00;
        sys_rst = 1'b1;
        repeat (8) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        t_reset;
        t_decode;
        t_page;
        t_xram;
        report_and_stop;
    end
endmodule // tb_top
